// >>> src/rsd_consts.vh
// Timing counts, thresholds and screen codes for the reed switch display controller
`ifndef RSD_CONSTS_VH
`define RSD_CONSTS_VH
`define RSD_CLK_MHZ 200
`define RSD_SESSION_S 20
`define RSD_SWINFO_S 3
`define RSD_HOLD_S 3
`define RSD_RESULT_S 300
`define RSD_ROTATE_S 2
`define RSD_DEBOUNCE_US 10000
`define RSD_SEG_NUM 4'h8
`define RSD_SOC_FULL 7'h5A
`define RSD_SOC_TWO 7'h28
`define RSD_SOC_ONE 7'h0A
`define RSD_SOC_RED 7'h05
`define RSD_SCR_OFF 4'h0
`define RSD_SCR_SWINFO 4'h1
`define RSD_SCR_STATUS 4'h2
`define RSD_SCR_HOLD 4'h3
`define RSD_SCR_TRANSPORT 4'h4
`define RSD_SCR_LINKSET 4'h5
`define RSD_SCR_CONNECT 4'h6
`define RSD_SCR_SYNC 4'h7
`define RSD_SCR_WAIT 4'h8
`define RSD_SCR_SETUP 4'h9
`define RSD_SCR_RESULT 4'hA
`define RSD_SCR_ERROR 4'hB
`define RSD_SCR_MODBAT 4'hC
`define RSD_SCR_LOGBAT 4'hD
`define RSD_ERR_NONE 6'h00
`define RSD_ERR_CONN 6'h02
`define RSD_ERR_MEAS 6'h03
`define RSD_ERR_BUFBAT 6'h0E
`define RSD_ERR_LINE 6'h1F
`define RSD_BAT_EMPTY 2'h0
`define RSD_BAT_THIRD 2'h1
`define RSD_BAT_TWO 2'h2
`define RSD_BAT_FULL 2'h3
`endif

// >>> src/rsd_top.v
// Reed switch timing, display session sequencing and screen selection
//
// Operation
// R1 - Brief press shows display for 20 s
// R2 - Three second hold enters setup mode
// R3 - Display turns on when switch closes
// R4 - Progress ring fills; setup when ring full
// R5 - Session: 3 s software info, then status
// R6 - Activation module insertion starts a session
// R7 - Battery icon level from charge percentage
// R8 - Below 5 percent icon drawn red
// R9 - Rotate fill level through coupled modules
// R10 - Module details follow displayed module
// R11 - One dot per module, hidden if single
// R12 - Setup shows signal level and countdown
// R13 - Setup results shown for five minutes
// R14 - Error codes for connection, measurement failure
// R15 - Error code for low buffer battery
// R16 - Error code for broken sensor line
// R17 - Distinct screen per operating state
// R18 - Battery replacement screens, module and logger
// R19 - Debounce switch; early release no setup
`timescale 1ns/1ps
`include "rsd_consts.vh"
module rsd_top #(
	// Counts are 40 bits: 32-bit math overflows the five-minute result window
	parameter [39:0] SESSION_CYC =
		40'h00_000F_4240 * `RSD_SESSION_S * `RSD_CLK_MHZ,
	parameter [39:0] SWINFO_CYC =
		40'h00_000F_4240 * `RSD_SWINFO_S * `RSD_CLK_MHZ,
	parameter [39:0] HOLD_CYC =
		40'h00_000F_4240 * `RSD_HOLD_S * `RSD_CLK_MHZ,
	parameter [39:0] RESULT_CYC =
		40'h00_000F_4240 * `RSD_RESULT_S * `RSD_CLK_MHZ,
	parameter [39:0] ROTATE_CYC =
		40'h00_000F_4240 * `RSD_ROTATE_S * `RSD_CLK_MHZ,
	parameter [39:0] DEBOUNCE_CYC =
		40'h00_0000_0001 * `RSD_DEBOUNCE_US * `RSD_CLK_MHZ
)
(
	// Clock, reset, enable
	input wire i_clk_sys,
	input wire i_rst_n,
	input wire i_ce,
	// User and device events
	input wire i_reed_closed,
	input wire i_act_inserted,
	// Operating state
	input wire i_transport,
	input wire i_linkset,
	input wire i_connecting,
	input wire i_syncing,
	input wire i_conn_wait,
	input wire i_setup_done,
	input wire [3:0] i_sig_level,
	input wire [11:0] i_setup_left_s,
	// Faults and batteries
	input wire i_err_conn,
	input wire i_err_meas,
	input wire i_err_bufbat,
	input wire i_err_line,
	input wire i_logbat_replace,
	input wire [3:0] i_modbat_replace,
	input wire [6:0] i_soc_pct,
	// Coupled modules, one bit each
	input wire [3:0] i_mod_coupled,
	// Display outputs
	output reg o_disp_on,
	output reg [3:0] o_screen,
	output reg [3:0] o_ring_green,
	output reg o_setup_start,
	output reg o_setup_active,
	output reg [1:0] o_bat_level,
	output reg o_bat_red,
	output reg [1:0] o_mod_sel,
	output reg [3:0] o_dots_show,
	output reg [3:0] o_sig_level,
	output reg [11:0] o_countdown_s,
	output reg [5:0] o_err_code
);

	localparam ST_IDLE = 2'h0;
	localparam ST_HOLD = 2'h1;
	localparam ST_SESS = 2'h2;
	localparam ST_SETUP = 2'h3;

	// Battery icon level; used only by the registered o_bat_level output
	function [1:0] bat_lvl;
		input [6:0] soc;
		begin
			if (soc >= `RSD_SOC_FULL)
				bat_lvl = `RSD_BAT_FULL;
			else if (soc >= `RSD_SOC_TWO)
				bat_lvl = `RSD_BAT_TWO;
			else if (soc >= `RSD_SOC_ONE)
				bat_lvl = `RSD_BAT_THIRD;
			else
				bat_lvl = `RSD_BAT_EMPTY;
		end
	endfunction

	// Next coupled module after cur, wrapping; stays put if none other
	function [1:0] next_mod;
		input [1:0] cur;
		input [3:0] msk;
		reg [1:0] k;
		reg [1:0] c;
		reg found;
		integer i;
		begin
			next_mod = cur;
			found = 1'b0;
			for (i = 1; i < 4; i = i + 1)
			begin
				k = i[1:0];
				c = cur + k;
				if (!found && msk[c])
				begin
					next_mod = c;
					found = 1'b1;
				end
			end
		end
	endfunction

	reg [1:0] state_r;
	reg [31:0] db_cnt_r;
	reg reed_db_r;
	reg [31:0] hold_cnt_r;
	reg [31:0] sess_cnt_r;
	// Five minutes of cycles needs 36 bits
	reg [39:0] res_cnt_r;
	reg [31:0] rot_cnt_r;
	reg result_r;
	reg act_prev_r;
	reg [3:0] screen_nxt;
	reg [5:0] err_nxt;

	wire act_rise = i_act_inserted & ~act_prev_r;
	wire [2:0] mod_count = {2'b00, i_mod_coupled[0]} +
		{2'b00, i_mod_coupled[1]} + {2'b00, i_mod_coupled[2]} +
		{2'b00, i_mod_coupled[3]};
	// Quotient stays below the segment count while holding
	wire [39:0] ring_q = hold_cnt_r / (HOLD_CYC / `RSD_SEG_NUM);

	// Debounce: accept a new level only after it holds steady
	always @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			db_cnt_r <= 32'h0000_0000;
			reed_db_r <= 1'b0;
			act_prev_r <= 1'b0;
		end
		else if (i_ce)
		begin
			act_prev_r <= i_act_inserted;
			if (i_reed_closed == reed_db_r)
				db_cnt_r <= 32'h0000_0000;
			else if (db_cnt_r >= DEBOUNCE_CYC - 1)
			begin
				reed_db_r <= i_reed_closed; // [R19]
				db_cnt_r <= 32'h0000_0000;
			end
			else
				db_cnt_r <= db_cnt_r + 32'h0000_0001;
		end
	end

	// Main sequencer: hold timing, session and setup
	always @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state_r <= ST_IDLE;
			hold_cnt_r <= 32'h0000_0000;
			sess_cnt_r <= 32'h0000_0000;
			res_cnt_r <= 40'h00_0000_0000;
			result_r <= 1'b0;
			o_setup_start <= 1'b0;
			o_setup_active <= 1'b0;
			o_ring_green <= 4'h0;
		end
		else if (i_ce)
		begin
			o_setup_start <= 1'b0;
			// Result screen runs its own 5 minute window
			if (result_r)
			begin
				if (res_cnt_r >= RESULT_CYC - 1)
					result_r <= 1'b0; // [R13]
				else
					res_cnt_r <= res_cnt_r + 40'h00_0000_0001;
			end
			case (state_r)
				ST_IDLE, ST_SESS:
				begin
					if (reed_db_r)
					begin
						state_r <= ST_HOLD; // [R3]
						hold_cnt_r <= 32'h0000_0000;
						o_ring_green <= 4'h0;
					end
					else if (act_rise)
					begin
						state_r <= ST_SESS; // [R6]
						sess_cnt_r <= 32'h0000_0000;
					end
					else if (state_r == ST_SESS)
					begin
						if (sess_cnt_r >= SESSION_CYC - 1)
							state_r <= ST_IDLE; // [R1] [R5]
						else
							sess_cnt_r <= sess_cnt_r + 32'h0000_0001;
					end
				end
				ST_HOLD:
				begin
					// Ring segments proportional to hold time
					o_ring_green <= ring_q[3:0]; // [R4]
					if (!reed_db_r)
					begin
						// Early release: plain session only
						state_r <= ST_SESS; // [R1] [R19]
						sess_cnt_r <= 32'h0000_0000;
					end
					else if (hold_cnt_r >= HOLD_CYC - 1)
					begin
						state_r <= ST_SETUP; // [R2] [R4]
						o_ring_green <= `RSD_SEG_NUM;
						o_setup_start <= 1'b1;
						o_setup_active <= 1'b1;
					end
					else
						hold_cnt_r <= hold_cnt_r + 32'h0000_0001;
				end
				ST_SETUP:
				begin
					if (i_setup_done)
					begin
						o_setup_active <= 1'b0;
						result_r <= 1'b1; // [R13]
						res_cnt_r <= 40'h00_0000_0000;
						state_r <= ST_IDLE;
					end
				end
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

	// Module rotation; restarts when the shown module is decoupled, via mask check
	always @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rot_cnt_r <= 32'h0000_0000;
			o_mod_sel <= 2'h0;
			o_dots_show <= 4'h0;
		end
		else if (i_ce)
		begin
			if (!i_mod_coupled[o_mod_sel] ||
				rot_cnt_r >= ROTATE_CYC - 1)
			begin
				o_mod_sel <= next_mod(o_mod_sel, i_mod_coupled); // [R9]
				rot_cnt_r <= 32'h0000_0000;
			end
			else
				rot_cnt_r <= rot_cnt_r + 32'h0000_0001;
			// Dots only make sense with two or more modules
			o_dots_show <= (mod_count > 3'd1) ?
				i_mod_coupled : 4'h0; // [R11]
		end
	end

	// Error code priority: newest-impact faults first
	always @*
	begin
		err_nxt = `RSD_ERR_NONE;
		if (i_err_line)
			err_nxt = `RSD_ERR_LINE; // [R16]
		else if (i_err_bufbat)
			err_nxt = `RSD_ERR_BUFBAT; // [R15]
		else if (i_err_meas)
			err_nxt = `RSD_ERR_MEAS; // [R14]
		else if (i_err_conn)
			err_nxt = `RSD_ERR_CONN; // [R14]
	end

	// Screen selection; hold and setup override session content
	always @*
	begin
		screen_nxt = `RSD_SCR_OFF;
		if (state_r == ST_HOLD)
			screen_nxt = `RSD_SCR_HOLD; // [R3] [R17]
		else if (state_r == ST_SETUP)
			screen_nxt = `RSD_SCR_SETUP; // [R12]
		else if (result_r)
			screen_nxt = `RSD_SCR_RESULT; // [R13]
		else if (state_r == ST_SESS)
		begin
			if (sess_cnt_r < SWINFO_CYC)
				screen_nxt = `RSD_SCR_SWINFO; // [R5]
			else if (i_transport && !i_act_inserted)
				screen_nxt = `RSD_SCR_TRANSPORT; // [R17]
			else if (i_linkset)
				screen_nxt = `RSD_SCR_LINKSET; // [R17]
			else if (i_connecting)
				screen_nxt = `RSD_SCR_CONNECT; // [R17]
			else if (i_syncing)
				screen_nxt = `RSD_SCR_SYNC; // [R17]
			else if (i_conn_wait)
				screen_nxt = `RSD_SCR_WAIT; // [R17]
			else if (err_nxt != `RSD_ERR_NONE)
				screen_nxt = `RSD_SCR_ERROR; // [R14]
			else if (i_logbat_replace)
				screen_nxt = `RSD_SCR_LOGBAT; // [R18]
			else if (i_modbat_replace[o_mod_sel])
				screen_nxt = `RSD_SCR_MODBAT; // [R18] [R10]
			else
				screen_nxt = `RSD_SCR_STATUS; // [R10]
		end
	end

	// Registered display outputs
	always @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_disp_on <= 1'b0;
			o_screen <= `RSD_SCR_OFF;
			o_bat_level <= `RSD_BAT_EMPTY;
			o_bat_red <= 1'b0;
			o_sig_level <= 4'h0;
			o_countdown_s <= 12'h000;
			o_err_code <= `RSD_ERR_NONE;
		end
		else if (i_ce)
		begin
			o_screen <= screen_nxt;
			o_disp_on <= (screen_nxt != `RSD_SCR_OFF);
			o_bat_level <= bat_lvl(i_soc_pct); // [R7]
			o_bat_red <= (i_soc_pct < `RSD_SOC_RED); // [R8]
			o_sig_level <= i_sig_level; // [R12]
			o_countdown_s <= i_setup_left_s; // [R12]
			o_err_code <= err_nxt;
		end
	end
endmodule

// >>> verif/rsd_assertions.sv
// Port assertions for the reed switch display controller
`timescale 1ns/1ps
module rsd_checker (
	// Clock, reset and enable
	input wire i_clk_sys,
	input wire i_rst_n,
	input wire i_ce,
	// Watched ports
	input wire [3:0] i_sig_level,
	input wire o_disp_on,
	input wire [3:0] o_screen,
	input wire [3:0] o_ring_green,
	input wire o_setup_start,
	input wire o_setup_active,
	input wire [1:0] o_bat_level,
	input wire o_bat_red,
	input wire [3:0] o_dots_show,
	input wire [3:0] o_sig_level,
	input wire [5:0] o_err_code
);
	// One domain, so clock and reset are given once
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	disp_on_a:
	assert property (o_disp_on == (o_screen != 4'h0)) else $error("disp");
	ring_max_a:
	assert property (o_ring_green <= 4'h8) else $error("ring over");
	ring_full_a:
	assert property (o_setup_start |-> o_ring_green == 4'h8)
		else $error("ring not full");
	start_pulse_a:
	assert property (o_setup_start |=> !o_setup_start) else $error("pulse");
	setup_on_a:
	assert property (o_setup_start |=> o_setup_active) else $error("setup");
	red_empty_a:
	assert property (o_bat_red |-> o_bat_level == 2'h0) else $error("red");
	dots_multi_a:
	assert property (o_dots_show != 4'h0 |-> $countones(o_dots_show) > 1)
		else $error("dots");
	sig_copy_a:
	assert property ($past(i_rst_n) && $past(i_ce) |->
		o_sig_level == $past(i_sig_level)) else $error("signal");
	err_code_a:
	assert property (o_err_code inside {6'h00, 6'h02, 6'h03, 6'h0E, 6'h1F})
		else $error("code");
endmodule

bind rsd_top rsd_checker i_chk (.*);

// >>> verif/rsd_user_model.sv
// Behavioural user holding the magnet at the reed switch
`timescale 1ns/1ps
module rsd_user_model (
	// Clock in, switch level out
	input wire i_clk_sys,
	output reg o_reed_closed
);
	integer k;
	initial o_reed_closed = 1'b0;
	// Contact bounces: 2-cycle blip, 2-cycle gap, then n+1 cycles closed
	task press(input integer n);
		for (k = 0; k < 4; k = k + 1)
		begin
			@(posedge i_clk_sys);
			#1 o_reed_closed = ~o_reed_closed;
			repeat (k == 2 ? n : k == 3 ? 0 : 1) @(posedge i_clk_sys);
		end
	endtask
endmodule

// >>> verif/rsd_top_tb.sv
// Self-checking bench for the reed switch display controller
`timescale 1ns/1ps
module rsd_top_tb;
	// Bench state and design inputs
	reg clk = 1'b0, rst_n = 1'b0, act = 1'b0, sd = 1'b0, ce = 1'b1;
	reg [5:0] frz;
	reg [6:0] st = 7'h00, soc = 7'h32;
	reg [3:0] sig = 4'h0, mc = 4'h1, eh = 4'h0, mb = 4'h0, seen;
	reg [11:0] left = 12'h000;
	reg [16:0] rnd = 17'h122E9;
	reg [69:0] cvp = {7'h00, 7'h04, 7'h05, 7'h09, 7'h0A, 7'h27, 7'h28,
		7'h59, 7'h5A, 7'h64};
	integer err_total = 0, samples_checked = 0, cyc = 0, starts = 0;
	integer i, n, t0;
	wire reed, disp, sst, sact, red;
	wire [3:0] scr, ring, dots, osig;
	wire [1:0] bat, sel;
	wire [11:0] cnt;
	wire [5:0] err;
	initial forever #2.5 clk = ~clk;
	// Short counts keep the run brief
	rsd_top #(.SESSION_CYC(200), .SWINFO_CYC(30), .HOLD_CYC(80),
		.RESULT_CYC(100), .ROTATE_CYC(20), .DEBOUNCE_CYC(4)) i_dut (
		.i_clk_sys(clk), .i_rst_n(rst_n), .i_ce(ce),
		.i_reed_closed(reed), .i_act_inserted(act),
		.i_transport(st[0]), .i_linkset(st[1]), .i_connecting(st[2]),
		.i_syncing(st[3]), .i_conn_wait(st[4]), .i_setup_done(sd),
		.i_sig_level(sig), .i_setup_left_s(left), .i_err_conn(eh[0]),
		.i_err_meas(eh[1]), .i_err_bufbat(eh[2]), .i_err_line(eh[3]),
		.i_logbat_replace(st[5]), .i_modbat_replace(mb),
		.i_soc_pct(soc), .i_mod_coupled(mc), .o_disp_on(disp),
		.o_screen(scr), .o_ring_green(ring), .o_setup_start(sst),
		.o_setup_active(sact), .o_bat_level(bat), .o_bat_red(red),
		.o_mod_sel(sel), .o_dots_show(dots), .o_sig_level(osig),
		.o_countdown_s(cnt), .o_err_code(err));
	rsd_user_model i_user (.i_clk_sys(clk), .o_reed_closed(reed));
	function [16:0] lfsr(input [16:0] v);
		lfsr = {v[15:0], v[16] ^ v[13]};
	endfunction
	// Red flag and icon level expected for a charge
	function [2:0] batx(input [6:0] s);
		batx = {s < 7'h05, s >= 7'h5A ? 2'h3 : s >= 7'h28 ? 2'h2 :
			s >= 7'h0A ? 2'h1 : 2'h0};
	endfunction
	function [5:0] errx(input [3:0] k);
		errx = k == 0 ? 6'h00 : k == 1 ? 6'h02 : k == 2 ? 6'h03 :
			k == 3 ? 6'h0E : 6'h1F;
	endfunction
	function [3:0] scrx(input [3:0] k);
		scrx = k < 5 ? 4'h4 + k : k == 5 ? 4'hD : 4'hC;
	endfunction
	task chk(input ok, input [8*6:1] m);
		begin
			samples_checked = samples_checked + 1;
			if (ok !== 1'b1)
			begin
				err_total = err_total + 1;
				$display("MISMATCH %0t %0s", $time, m);
			end
		end
	endtask
	// Inputs change and outputs are read 1 ns after the edge
	task step(input integer c);
		begin
			repeat (c) @(posedge clk);
			#1;
		end
	endtask
	task wscr(input [3:0] s);
		begin
			for (n = 0; scr !== s && n < 400; n = n + 1)
				step(1);
			chk(scr === s, "screen");
		end
	endtask
	task wrap_up;
		begin
			$display("checks %0d mismatches %0d", samples_checked, err_total);
			if (err_total == 0 && samples_checked > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	// Setup starts are counted away from the edge; a hang is cut short
	always @(negedge clk)
	begin
		cyc = cyc + 1;
		if (sst === 1'b1)
			starts = starts + 1;
		if (cyc == 20000)
		begin
			err_total = err_total + 1;
			wrap_up;
		end
	end
	initial
	begin
		step(2);
		rst_n = 1'b1;
		step(1);
		chk(scr === 4'h0 && sst === 1'b0, "reset");
		// Brief bouncing press, session screens and state screens
		fork
			i_user.press(20);
			wscr(4'h3);
		join
		wscr(4'h1);
		t0 = cyc;
		wscr(4'h2);
		chk(cyc - t0 > 27 && cyc - t0 < 34, "swinfo");
		for (i = 0; i < 7; i = i + 1)
		begin
			st = 7'h01 << i;
			mb = {3'h0, st[6]};
			step(3);
			chk(scr === scrx(i), "state");
		end
		st = 7'h00;
		wscr(4'h0);
		chk(cyc - t0 > 194 && cyc - t0 < 206 && starts == 0, "sess");
		$display("test 1 done");
		// Long hold: ring fills, setup, then results
		fork
			i_user.press(120);
			begin
				step(50);
				chk(ring > 4'h0 && ring < 4'h8 && starts == 0, "ring");
			end
		join
		chk(starts == 1 && sact === 1'b1 && scr === 4'h9, "setup");
		rnd = lfsr(rnd);
		sig = rnd[3:0];
		left = rnd[16:5];
		// Let the release settle first, or idle re-enters hold
		step(6);
		chk(osig === sig && cnt === left, "sig");
		sd = 1'b1;
		wscr(4'hA);
		t0 = cyc;
		sd = 1'b0;
		wscr(4'h0);
		chk(cyc - t0 > 95 && cyc - t0 < 106, "result");
		$display("test 2 done");
		// Activation module session with modules in rotation
		chk(dots === 4'h0, "dots");
		mc = 4'hB;
		act = 1'b1;
		wscr(4'h1);
		mb = 4'h2;
		seen = 4'h0;
		for (i = 0; i < 80; i = i + 1)
		begin
			t0 = sel;
			step(1);
			seen = seen | (4'h1 << sel);
			if (i > 39)
				chk(scr === (t0 == 1 ? 4'hC : 4'h2), "modbat");
		end
		chk(dots === 4'hB && seen === 4'hB, "rotate");
		// Enable low must freeze rotation and screen alike
		ce = 1'b0;
		frz = {scr, sel};
		step(30);
		chk({scr, sel} === frz, "freeze");
		ce = 1'b1;
		act = 1'b0;
		$display("test 3 done");
		// Charge corners, then random charges
		for (i = 0; i < 30; i = i + 1)
		begin
			rnd = lfsr(rnd);
			soc = i < 10 ? cvp[i * 7 +: 7] : rnd[6:0] % 7'h65;
			step(3);
			chk({red, bat} === batx(soc), "bat");
		end
		// Each fault alone, then all at once
		for (i = 0; i < 6; i = i + 1)
		begin
			eh = i < 5 ? 4'h8 >> (4 - i) : 4'hF;
			step(3);
			chk(err === errx(i), "error");
		end
		$display("test 4 done");
		// Reset in mid-run clears the display at once
		rst_n = 1'b0;
		step(1);
		chk(scr === 4'h0 && disp === 1'b0 && sel === 2'h0, "reset");
		rst_n = 1'b1;
		step(2);
		chk(scr === 4'h0 && sst === 1'b0, "reset");
		$display("test 5 done");
		wrap_up;
	end
endmodule
